// [rtl/dnpt_defs.svh]
// Overview of operation
// - Selector 00 increments, 11 decrements data
// - Selector 01 walking ones, 10 walking zeros
// - Native data path is 32 bits wide
// - Write request asserted with burst start address
// - Controller steps address each beat
// - User drops write request after one cycle, as busy rises
// - Controller opens row: row, bank, select
// - Data request changes cycle before write
// - Each write command carries own column
// - Data request answered by next data word
// - Read request asserted with start address
// - Read valid with each word to burst end
// - Read data equals data written there
// - Read valid, delayed by two-entry buffer, is capture write enable
// - Capture buffer 1024 deep, 256 wide
// - User logic runs on controller user clock
// - Next operation repeats request sequence
`ifndef DNPT_DEFS_SVH
`define DNPT_DEFS_SVH
`define DNPT_DATA_W 32
`define DNPT_ADDR_W 10
`define DNPT_ROW_W 6
`define DNPT_COL_W 4
`define DNPT_BURST_W 5
`define DNPT_CAP_DEPTH 1024
`define DNPT_CAP_W 256
`define DNPT_CAP_AW 10
`define DNPT_MEM_DEPTH 1024
`define DNPT_BURST_LEN 5'h10
`define DNPT_ONE_DATA 32'h00000001
`define DNPT_ONES_DATA 32'hFFFFFFFF
`define DNPT_WZ_SEED 32'hFFFFFFFE
`define DNPT_ZERO_DATA 32'h00000000
`define DNPT_ADDR_STEP 10'h001
`define DNPT_ADDR_WRAP 10'h3FF
`define DNPT_BUF_DEPTH 2
`endif

// [rtl/dnpt_pkg.sv]
package dnpt_pkg;
  typedef logic [31:0] dnpt_data_t;
  typedef logic [9:0] dnpt_addr_t;
  typedef logic [1:0] dnpt_sel_t;
  typedef enum logic [1:0] {
    DNPT_PAT_INC, DNPT_PAT_WONE, DNPT_PAT_WZERO, DNPT_PAT_DEC
  } dnpt_pat_e;
endpackage

// [rtl/dnpt_if.sv]
`timescale 1ns/10ps
// Native fabric interface between user logic and controller
interface dnpt_if;
  logic write_request;
  logic read_request;
  dnpt_pkg::dnpt_addr_t address;
  logic [4:0] burst_size;
  logic busy;
  logic data_request;
  dnpt_pkg::dnpt_data_t write_data;
  logic read_valid;
  dnpt_pkg::dnpt_data_t read_data;
  modport ctrl (
    input write_request, read_request, address, burst_size, write_data,
    output busy, data_request, read_valid, read_data
  );
  modport user (
    output write_request, read_request, address, burst_size, write_data,
    input busy, data_request, read_valid, read_data
  );
endinterface

// [rtl/dnpt_skid_buf.sv]
`timescale 1ns/10ps
`include "dnpt_defs.svh"
// Two-entry valid/ready buffer; no word lost on stall
module dnpt_skid_buf (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire dnpt_pkg::dnpt_data_t in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output dnpt_pkg::dnpt_data_t out_data_out
);
  import dnpt_pkg::*;
  dnpt_data_t mem_q [`DNPT_BUF_DEPTH];
  dnpt_data_t mem_d [`DNPT_BUF_DEPTH];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  // Handshake and next-state for pointers and storage
  always_comb begin
    in_ready_out = (cnt_q != 2'h2);
    out_valid_out = (cnt_q != 2'h0);
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data_in;
      wp_d = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    case ({push, pop})
      2'b10: cnt_d = cnt_q + 2'h1;
      2'b01: cnt_d = cnt_q - 2'h1;
      default: cnt_d = cnt_q;
    endcase
  end

  assign out_data_out = mem_q[rp_q];

  // Register state
  always_ff @(posedge mclk_in) begin
    mem_q <= mem_d;
    if (!rst_n_in) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// [rtl/dnpt_ctrl.sv]
`timescale 1ns/10ps
`include "dnpt_defs.svh"
// Controller end: row open, column writes, read return
module dnpt_ctrl (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  dnpt_if.ctrl nif,
  output logic [`DNPT_ROW_W-1:0] row_addr_out,
  output logic bank_open_out,
  output logic chip_sel_n_out,
  output logic write_cmd_out,
  output logic [`DNPT_COL_W-1:0] col_addr_out
);
  import dnpt_pkg::*;
  typedef enum {
    DNPT_IDLE, DNPT_ACT, DNPT_WDAT, DNPT_RDAT
  } dnpt_st_e;
  dnpt_st_e st_q, st_d;
  dnpt_data_t mem_q [`DNPT_MEM_DEPTH];
  dnpt_addr_t addr_q, addr_d;
  logic [4:0] left_q, left_d;
  logic dreq_q, dreq_d, wcmd_q, wcmd_d, rv_q, rv_d;
  dnpt_data_t rd_q, rd_d;
  logic [`DNPT_ROW_W-1:0] row_q, row_d;
  logic cs_n_q, cs_n_d, rdflag_q, rdflag_d;
  dnpt_addr_t wa_q, wa_d;

  // Burst sequencing
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    left_d = left_q;
    dreq_d = 1'b0;
    wcmd_d = 1'b0;
    rv_d = 1'b0;
    rd_d = rd_q;
    row_d = row_q;
    cs_n_d = 1'b1;
    rdflag_d = rdflag_q;
    wa_d = wa_q;
    case (st_q)
      DNPT_IDLE: begin
        if (nif.write_request || nif.read_request) begin
          addr_d = nif.address;
          left_d = nif.burst_size;
          row_d = nif.address[`DNPT_ADDR_W-1:`DNPT_COL_W];
          cs_n_d = 1'b0;
          rdflag_d = !nif.write_request;
          st_d = DNPT_ACT;
        end
      end
      DNPT_ACT: begin
        st_d = rdflag_q ? DNPT_RDAT : DNPT_WDAT;
        dreq_d = !rdflag_q;
      end
      DNPT_WDAT: begin
        wcmd_d = 1'b1;
        wa_d = addr_q;
        addr_d = addr_q + `DNPT_ADDR_STEP;
        left_d = left_q - 5'h01;
        dreq_d = (left_q > 5'h01);
        if (left_q <= 5'h01) begin
          st_d = DNPT_IDLE;
        end
      end
      DNPT_RDAT: begin
        rv_d = 1'b1;
        rd_d = mem_q[addr_q];
        addr_d = addr_q + `DNPT_ADDR_STEP;
        left_d = left_q - 5'h01;
        if (left_q <= 5'h01) begin
          st_d = DNPT_IDLE;
        end
      end
      default: st_d = DNPT_IDLE;
    endcase
  end

  // Register state; write data taken one cycle after its request
  always_ff @(posedge mclk_in) begin
    if (wcmd_q) begin
      mem_q[wa_q] <= nif.write_data;
    end
    if (!rst_n_in) begin
      st_q <= DNPT_IDLE;
      addr_q <= '0;
      left_q <= '0;
      dreq_q <= 1'b0;
      wcmd_q <= 1'b0;
      rv_q <= 1'b0;
      rd_q <= '0;
      row_q <= '0;
      cs_n_q <= 1'b1;
      rdflag_q <= 1'b0;
      wa_q <= '0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      left_q <= left_d;
      dreq_q <= dreq_d;
      wcmd_q <= wcmd_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      row_q <= row_d;
      cs_n_q <= cs_n_d;
      rdflag_q <= rdflag_d;
      wa_q <= wa_d;
    end
  end

  // Native and memory-side outputs
  assign nif.busy = (st_q != DNPT_IDLE);
  assign nif.data_request = dreq_q;
  assign nif.read_valid = rv_q;
  assign nif.read_data = rd_q;
  assign row_addr_out = row_q;
  assign bank_open_out = !cs_n_q;
  assign chip_sel_n_out = cs_n_q;
  assign write_cmd_out = wcmd_q;
  assign col_addr_out = wa_q[`DNPT_COL_W-1:0];
endmodule

// [rtl/dnpt_user.sv]
`timescale 1ns/10ps
`include "dnpt_defs.svh"
// User end: pattern generator, requests, read capture
module dnpt_user (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  dnpt_if.user nif,
  input wire logic pattern_select_bit1_in,
  input wire logic pattern_select_bit0_in,
  input wire logic [`DNPT_CAP_AW-1:0] cap_rd_addr_in,
  output logic [`DNPT_CAP_W-1:0] cap_rd_data_out,
  output logic [`DNPT_CAP_AW-1:0] cap_count_out
);
  import dnpt_pkg::*;
  typedef enum {DNPT_U_WREQ, DNPT_U_WAIT, DNPT_U_RREQ, DNPT_U_RWAIT} dnpt_u_e;
  dnpt_u_e st_q, st_d;
  logic s1a_q, s1b_q, s0a_q, s0b_q;
  dnpt_data_t pat_q, pat_d, wd_q, wd_d;
  dnpt_sel_t sel_q;
  logic wreq_d, rreq_d, wreq_q, rreq_q;
  logic [`DNPT_CAP_W-1:0] cap_q [`DNPT_CAP_DEPTH];
  logic [`DNPT_CAP_AW-1:0] cwa_q, cwa_d;
  logic [`DNPT_CAP_W-1:0] crd_q;
  logic bv, bready;
  dnpt_data_t bdata;

  // Seed of each pattern
  function automatic dnpt_data_t seed(input dnpt_sel_t s);
    case (s)
      2'b01: seed = `DNPT_ONE_DATA;
      2'b10: seed = `DNPT_WZ_SEED;
      2'b11: seed = `DNPT_ONES_DATA;
      default: seed = `DNPT_ZERO_DATA;
    endcase
  endfunction

  // Pattern step
  function automatic dnpt_data_t step(input dnpt_sel_t s,
                                      input dnpt_data_t v);
    case (s)
      2'b00: step = v + `DNPT_ONE_DATA;
      2'b11: step = v - `DNPT_ONE_DATA;
      default: step = {v[30:0], v[31]};
    endcase
  endfunction

  // Switch synchronisers
  always_ff @(posedge mclk_in) begin
    s1a_q <= pattern_select_bit1_in;
    s1b_q <= s1a_q;
    s0a_q <= pattern_select_bit0_in;
    s0b_q <= s0a_q;
  end

  // Request sequencing and pattern advance
  always_comb begin
    st_d = st_q;
    pat_d = pat_q;
    wd_d = wd_q;
    wreq_d = 1'b0;
    rreq_d = 1'b0;
    if (nif.data_request) begin
      wd_d = pat_q;
      pat_d = step(sel_q, pat_q);
    end
    // A new selector value restarts the pattern from its seed
    if (sel_q != {s1b_q, s0b_q}) begin
      pat_d = seed({s1b_q, s0b_q});
    end
    case (st_q)
      DNPT_U_WREQ: begin
        if (!nif.busy && !wreq_q) begin
          wreq_d = 1'b1;
          st_d = DNPT_U_WAIT;
        end
      end
      DNPT_U_WAIT: if (!nif.busy && !wreq_q) st_d = DNPT_U_RREQ;
      DNPT_U_RREQ: begin
        if (!nif.busy && !rreq_q) begin
          rreq_d = 1'b1;
          st_d = DNPT_U_RWAIT;
        end
      end
      DNPT_U_RWAIT: begin
        if (!nif.busy && !rreq_q) begin
          st_d = DNPT_U_WREQ;
        end
      end
      default: st_d = DNPT_U_WREQ;
    endcase
  end

  // Register request state
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_q <= DNPT_U_WREQ;
      pat_q <= `DNPT_ZERO_DATA;
      wd_q <= `DNPT_ZERO_DATA;
      wreq_q <= 1'b0;
      rreq_q <= 1'b0;
      sel_q <= 2'b00;
    end else begin
      st_q <= st_d;
      wd_q <= wd_d;
      wreq_q <= wreq_d;
      rreq_q <= rreq_d;
      sel_q <= {s1b_q, s0b_q};
      pat_q <= pat_d;
    end
  end

  assign nif.write_request = wreq_q;
  assign nif.read_request = rreq_q;
  assign nif.address = '0;
  assign nif.burst_size = `DNPT_BURST_LEN;
  assign nif.write_data = wd_q;

  // Read words pass a two-entry buffer on the way to capture
  dnpt_skid_buf u_buf (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(nif.read_valid),
    .in_ready_out(),
    .in_data_in(nif.read_data),
    .out_valid_out(bv),
    .out_ready_in(bready),
    .out_data_out(bdata)
  );
  assign bready = 1'b1;

  // Capture buffer write port and read port, one clock
  always_comb begin
    cwa_d = cwa_q;
    if (bv) begin
      cwa_d = cwa_q + `DNPT_ADDR_STEP;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (bv) begin
      cap_q[cwa_q] <= {{(`DNPT_CAP_W-`DNPT_DATA_W){1'b0}}, bdata};
    end
    crd_q <= cap_q[cap_rd_addr_in];
    if (!rst_n_in) begin
      cwa_q <= '0;
    end else begin
      cwa_q <= cwa_d;
    end
  end

  assign cap_rd_data_out = crd_q;
  assign cap_count_out = cwa_q;
endmodule

// [test/dnpt_chk.sv]
`timescale 1ns/10ps
`include "dnpt_defs.svh"
// Handshake and memory bus checks beside the native interface
module dnpt_chk (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic write_request,
  input wire logic read_request,
  input wire logic busy,
  input wire logic data_request,
  input wire logic read_valid,
  input wire logic write_cmd_out,
  input wire logic chip_sel_n_out,
  input wire logic [`DNPT_COL_W-1:0] col_addr_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Request acceptance and burst lengths
  wr_take_a: assert property (!busy && write_request |=> busy)
    else $error("write request not taken");
  rd_take_a: assert property (!busy && read_request |=> busy)
    else $error("read request not taken");
  wr_beats_a: assert property (!busy && write_request |-> ##2
    data_request[*8] ##1 data_request[*8] ##1 !data_request)
    else $error("data request beats wrong");
  rd_beats_a: assert property (!busy && read_request && !write_request
    |-> ##3 read_valid[*8] ##1 read_valid[*8] ##1 !read_valid)
    else $error("read valid beats wrong");
  // Memory bus command order and columns; no request while busy
  row_open_a: assert property (!busy && write_request |=> !chip_sel_n_out)
    else $error("row not opened");
  cmd_follow_a: assert property (data_request |=> write_cmd_out)
    else $error("write command missing");
  cmd_end_a: assert property ($fell(data_request) |->
    write_cmd_out ##1 !write_cmd_out)
    else $error("write command count wrong");
  col_start_a: assert property ($rose(write_cmd_out) |-> col_addr_out == '0)
    else $error("first column wrong");
  col_step_a: assert property (write_cmd_out && $past(write_cmd_out) |->
    col_addr_out == $past(col_addr_out) + 1'b1)
    else $error("column did not step");
  quiet_busy_a: assert property (busy |-> !write_request && !read_request)
    else $error("request while busy");
endmodule

// [test/testbench.sv]
`timescale 1ns/10ps
`include "dnpt_defs.svh"
module testbench;
  import dnpt_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sel1 = 1'b0;
  logic sel0 = 1'b0;
  logic rv_q = 1'b0;
  logic [9:0] rd_addr = '0;
  logic [255:0] rd_data;
  logic [9:0] count;
  logic [5:0] row;
  logic bank, cs_n, wcmd;
  logic [3:0] col;
  int err_total = 0;
  int num_checks = 0;
  int nrd = 0;
  int nfall = 0;
  int seed = 32'h9102DE31;
  int m, p, b;
  int base = 0;
  int beat = 0;
  int idx;
  dnpt_data_t wm[int];
  dnpt_data_t rq[$];

  dnpt_if nif ();
  dnpt_ctrl dnpt_ctrl_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .nif(nif),
    .row_addr_out(row), .bank_open_out(bank), .chip_sel_n_out(cs_n),
    .write_cmd_out(wcmd), .col_addr_out(col));
  dnpt_user dnpt_user_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .nif(nif),
    .pattern_select_bit1_in(sel1), .pattern_select_bit0_in(sel0),
    .cap_rd_addr_in(rd_addr), .cap_rd_data_out(rd_data),
    .cap_count_out(count));
  dnpt_chk dnpt_chk_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .write_request(nif.write_request), .read_request(nif.read_request),
    .busy(nif.busy), .data_request(nif.data_request),
    .read_valid(nif.read_valid), .write_cmd_out(wcmd),
    .chip_sel_n_out(cs_n), .col_addr_out(col));

  // Clock and watchdog
  always #5 mclk_in = ~mclk_in;
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    summarize();
  end

  // Memory model: words stored by address, returned words compared
  always @(posedge mclk_in) begin
    if (nif.busy === 1'b0 &&
        (nif.write_request === 1'b1 || nif.read_request === 1'b1)) begin
      base = nif.address;
      beat = 0;
    end
    if (cs_n === 1'b0) begin
      check("row address", {26'h0, row}, base >> `DNPT_COL_W);
      check("bank open", {31'h0, bank}, 32'h1);
    end
    if (wcmd === 1'b1) begin
      idx = (base + beat) % `DNPT_MEM_DEPTH;
      wm[idx] = nif.write_data;
      beat++;
    end
    if (nif.read_valid === 1'b1) begin
      idx = (base + beat) % `DNPT_MEM_DEPTH;
      check("read back", nif.read_data, wm[idx]);
      beat++;
      rq.push_back(nif.read_data);
      nrd++;
    end
    if (rv_q && !nif.read_valid) nfall++;
    rv_q <= nif.read_valid;
  end

  // Pattern model: next word for a selector value
  function automatic dnpt_data_t nxt(int md, dnpt_data_t v);
    case (md)
      0: return v + 32'h1;
      3: return v - 32'h1;
      default: return {v[30:0], v[31]};
    endcase
  endfunction

  task automatic check(string what, dnpt_data_t seen, dnpt_data_t exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Every selector, then random ones; check a clean burst each time
  initial begin
    repeat (8) @(posedge mclk_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 16; i++) begin
      m = (i < 4) ? i : ($random(seed) & 3);
      sel1 = m[1];
      sel0 = m[0];
      p = nfall + 3;
      while (nfall < p) begin
        @(posedge mclk_in);
        #1;
      end
      b = rq.size() - 16;
      for (int k = 1; k < 16; k++)
        check("read word", rq[b+k], nxt(m, rq[b+k-1]));
      if (m == 1 || m == 2)
        check("walk bits", $countones(rq[b]), (m == 1) ? 1 : 31);
      check("capture count", {22'h0, count}, nrd % 1024);
      p = count;
      for (int k = 0; k < 16; k++) begin
        rd_addr = p[9:0] - 10'h010 + k[9:0];
        @(posedge mclk_in);
        #1;
        check("capture word", rd_data[31:0], rq[b+k]);
        check("capture pad", {31'h0, |rd_data[255:32]}, 32'h0);
      end
    end
    summarize();
  end
endmodule
